//--- rtl/nhif_pkg.sv
package nhif_pkg;
    // register bus
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    // status and mask register offsets
    localparam logic [7:0] STAT_MAIN_ADDR = 8'h00;
    localparam logic [7:0] STAT_TNFC_ADDR = 8'h01;
    localparam logic [7:0] STAT_ERR_ADDR = 8'h02;
    localparam logic [7:0] STAT_PT_ADDR = 8'h03;
    localparam logic [7:0] MASK_MAIN_ADDR = 8'h04;
    localparam logic [7:0] MASK_TNFC_ADDR = 8'h05;
    localparam logic [7:0] MASK_ERR_ADDR = 8'h06;
    localparam logic [7:0] MASK_PT_ADDR = 8'h07;
    // buffer and control offsets
    localparam logic [7:0] FIFO_DATA_ADDR = 8'h08;
    localparam logic [7:0] FIFO_STAT1_ADDR = 8'h09;
    localparam logic [7:0] FIFO_STAT2_ADDR = 8'h0a;
    localparam logic [7:0] TX_LEN1_ADDR = 8'h0b;
    localparam logic [7:0] TX_LEN2_ADDR = 8'h0c;
    localparam logic [7:0] CMD_ADDR = 8'h0d;
    localparam logic [7:0] LMEM_BASE_ADDR = 8'h40;
    // command bits
    localparam int CMD_SET_DEFAULT_BIT = 0;
    localparam int CMD_STOP_ALL_BIT = 1;
    localparam int CMD_CLEAR_FIFO_BIT = 2;
    // second buffer status fields
    localparam int FSTAT2_CNT_HI_LSB = 0;
    localparam int FSTAT2_UNF_BIT = 4;
    localparam int FSTAT2_OVF_BIT = 5;
    // buffer geometry
    localparam int FIFO_DEPTH = 512;
    localparam int FIFO_PTR_W = 9;
    localparam int FIFO_CNT_W = 10;
    localparam logic [9:0] FIFO_FULL_CNT = 10'h200;
    localparam int TX_LEN_W = 10;
    // listen response memory layout
    localparam int LMEM_SIZE = 48;
    localparam logic [5:0] LMEM_LAST = 6'h2f;
    localparam logic [5:0] LMEM_ID_FIRST = 6'h00;
    localparam logic [5:0] LMEM_ID_LAST = 6'h09;
    localparam logic [5:0] LMEM_SENS_FIRST = 6'h0a;
    localparam logic [5:0] LMEM_SENS_LAST = 6'h0b;
    localparam logic [5:0] LMEM_TSN_FIRST = 6'h24;
    localparam logic [5:0] LMEM_TSN_LAST = 6'h2f;
    localparam logic [4:0] TSN_COUNT = 5'h18;
    localparam logic [4:0] TSN_LOW_LEFT = 5'h04;
    localparam logic [2:0] SLOT_MAX_BITS = 3'h4;
    // slot-low flag position in the passive listen status register
    localparam int PT_SLOT_LOW_BIT = 7;
    // reset values
    localparam logic [7:0] STAT_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [9:0] TX_LEN_RST = 10'h000;
endpackage

//--- rtl/nhif_top.sv
`timescale 1ns/100ps
module nhif_top
(
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    // interrupt event pulses
    input wire logic [7:0] i_ev_main,
    input wire logic [7:0] i_ev_tnfc,
    input wire logic [7:0] i_ev_err,
    input wire logic [7:0] i_ev_pt,
    // receive framer
    input wire logic i_rx_start,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    // transmit framer
    input wire logic i_tx_active,
    input wire logic i_tx_pop,
    output logic [7:0] o_tx_data,
    output logic [9:0] o_tx_len,
    // slot selection
    input wire logic i_slot_req,
    input wire logic [2:0] i_slot_bits,
    output logic [3:0] o_slot_num,
    // listen response memory readout
    input wire logic [5:0] i_lmem_addr,
    output logic [7:0] o_lmem_data,
    // interrupt pin
    output logic o_irq
);
    logic [7:0] stat [4];
    logic [7:0] mask [4];
    logic [7:0] ev [4];
    logic [7:0] fifo_mem [nhif_pkg::FIFO_DEPTH];
    logic [7:0] lmem [nhif_pkg::LMEM_SIZE];
    logic [8:0] wr_ptr;
    logic [8:0] rd_ptr;
    logic [9:0] fifo_cnt;
    logic ovf;
    logic unf;
    logic [9:0] tx_len;
    logic [4:0] tsn_idx;
    logic slot_low_ev;
    logic cmd_wr;
    logic clr_irq_all;
    logic fifo_reset;
    logic host_wr_fifo;
    logic host_rd_fifo;
    logic do_push;
    logic do_pop;
    logic fifo_empty;
    logic fifo_full;
    logic [7:0] pop_data;
    logic [7:0] next_rdata;
    logic next_irq;
    logic [5:0] lmem_wr_idx;
    logic [5:0] tsn_loc;
    logic [7:0] tsn_byte;
    logic [3:0] tsn_nib;
    logic [4:0] tsn_left;

    assign cmd_wr = i_wr && (i_addr == nhif_pkg::CMD_ADDR);
    assign clr_irq_all = cmd_wr && (i_wdata[nhif_pkg::CMD_SET_DEFAULT_BIT]
        || i_wdata[nhif_pkg::CMD_STOP_ALL_BIT] || i_wdata[nhif_pkg::CMD_CLEAR_FIFO_BIT]);
    assign fifo_reset = i_rx_start || (cmd_wr && (i_wdata[nhif_pkg::CMD_SET_DEFAULT_BIT]
        || i_wdata[nhif_pkg::CMD_CLEAR_FIFO_BIT]));

    // slot-low joins the passive listen group
    always_comb
    begin
        ev[0] = i_ev_main;
        ev[1] = i_ev_tnfc;
        ev[2] = i_ev_err;
        ev[3] = i_ev_pt;
        ev[3][nhif_pkg::PT_SLOT_LOW_BIT] = i_ev_pt[nhif_pkg::PT_SLOT_LOW_BIT] || slot_low_ev;
    end

    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1)
        begin : g_grp
            always_ff @(posedge i_sys_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    stat[g] <= nhif_pkg::STAT_RST;
                end
                else if (i_clk_en)
                begin
                    if (clr_irq_all || (i_rd && i_addr == 8'(g)))
                    begin
                        stat[g] <= ev[g];
                    end
                    else
                    begin
                        stat[g] <= stat[g] | ev[g];
                    end
                end
            end

            always_ff @(posedge i_sys_clk or negedge i_rst_n)
            begin
                if (!i_rst_n)
                begin
                    mask[g] <= nhif_pkg::MASK_RST;
                end
                else if (i_clk_en && i_wr && i_addr == (nhif_pkg::MASK_MAIN_ADDR + 8'(g)))
                begin
                    mask[g] <= i_wdata;
                end
            end
        end
    endgenerate

    // irq from next status and mask
    always_comb
    begin
        logic [7:0] ns;
        logic [7:0] nm;
        ns = 8'h00;
        nm = 8'h00;
        next_irq = 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            ns = stat[k] | ev[k];
            nm = mask[k];
            if (clr_irq_all || (i_rd && i_addr == 8'(k)))
            begin
                ns = ev[k];
            end
            if (i_wr && i_addr == (nhif_pkg::MASK_MAIN_ADDR + 8'(k)))
            begin
                nm = i_wdata;
            end
            next_irq = next_irq || |(ns & ~nm);
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_irq <= 1'b0;
        end
        else if (i_clk_en)
        begin
            o_irq <= next_irq;
        end
    end

    // receive data takes the write side over the host in each cycle with i_rx_valid
    assign host_wr_fifo = i_wr && (i_addr == nhif_pkg::FIFO_DATA_ADDR) && !i_rx_valid;
    assign host_rd_fifo = i_rd && (i_addr == nhif_pkg::FIFO_DATA_ADDR) && !i_tx_pop;
    assign fifo_empty = (fifo_cnt == 10'h000);
    assign fifo_full = (fifo_cnt == nhif_pkg::FIFO_FULL_CNT);
    assign do_push = (i_rx_valid || host_wr_fifo) && !fifo_full && !fifo_reset;
    assign do_pop = (i_tx_pop || host_rd_fifo) && !fifo_empty && !fifo_reset;
    assign pop_data = fifo_empty ? 8'h00 : fifo_mem[rd_ptr];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && do_push)
        begin
            fifo_mem[wr_ptr] <= i_rx_valid ? i_rx_data : i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            wr_ptr <= 9'h000;
            rd_ptr <= 9'h000;
            fifo_cnt <= 10'h000;
        end
        else if (i_clk_en)
        begin
            if (fifo_reset)
            begin
                wr_ptr <= 9'h000;
                rd_ptr <= 9'h000;
                fifo_cnt <= 10'h000;
            end
            else
            begin
                if (do_push)
                begin
                    wr_ptr <= wr_ptr + 9'h001;
                end
                if (do_pop)
                begin
                    rd_ptr <= rd_ptr + 9'h001;
                end
                if (do_push && !do_pop)
                begin
                    fifo_cnt <= fifo_cnt + 10'h001;
                end
                else if (do_pop && !do_push)
                begin
                    fifo_cnt <= fifo_cnt - 10'h001;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            ovf <= 1'b0;
            unf <= 1'b0;
        end
        else if (i_clk_en)
        begin
            if (fifo_reset)
            begin
                ovf <= 1'b0;
                unf <= 1'b0;
            end
            else
            begin
                if ((i_rx_valid || host_wr_fifo) && fifo_full)
                begin
                    ovf <= 1'b1;
                end
                // a late transmit byte shows as a framer pop on empty
                if ((i_tx_pop && i_tx_active && fifo_empty) || (host_rd_fifo && fifo_empty))
                begin
                    unf <= 1'b1;
                end
            end
        end
    end

    // transmit byte count and framer byte
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tx_len <= nhif_pkg::TX_LEN_RST;
        end
        else if (i_clk_en && i_wr)
        begin
            if (i_addr == nhif_pkg::TX_LEN1_ADDR)
            begin
                tx_len[7:0] <= i_wdata;
            end
            else if (i_addr == nhif_pkg::TX_LEN2_ADDR)
            begin
                tx_len[9:8] <= i_wdata[1:0];
            end
        end
    end

    assign o_tx_len = tx_len;

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_tx_data <= 8'h00;
        end
        else if (i_clk_en && i_tx_pop)
        begin
            o_tx_data <= fifo_reset ? 8'h00 : pop_data;
        end
    end

    // listen response memory, host writes by location
    assign lmem_wr_idx = i_addr[5:0];

    always_ff @(posedge i_sys_clk)
    begin
        if (i_clk_en && i_wr && i_addr >= nhif_pkg::LMEM_BASE_ADDR
            && lmem_wr_idx <= nhif_pkg::LMEM_LAST && i_addr[7:6] == 2'b01)
        begin
            lmem[lmem_wr_idx] <= i_wdata;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_lmem_data <= 8'h00;
        end
        else if (i_clk_en)
        begin
            o_lmem_data <= (i_lmem_addr <= nhif_pkg::LMEM_LAST) ? lmem[i_lmem_addr] : 8'h00;
        end
    end

    // two slot numbers per location, high nibble first
    assign tsn_loc = nhif_pkg::LMEM_TSN_FIRST + {2'b00, tsn_idx[4:1]};
    assign tsn_byte = lmem[tsn_loc];
    assign tsn_nib = tsn_idx[0] ? tsn_byte[3:0] : tsn_byte[7:4];
    assign tsn_left = nhif_pkg::TSN_COUNT - tsn_idx - 5'h01;

    // sequential use, index restarts on reload
    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            tsn_idx <= 5'h00;
            slot_low_ev <= 1'b0;
        end
        else if (i_clk_en)
        begin
            slot_low_ev <= 1'b0;
            if (i_wr && i_addr == (nhif_pkg::LMEM_BASE_ADDR + {2'b00, nhif_pkg::LMEM_TSN_FIRST}))
            begin
                tsn_idx <= 5'h00;
            end
            else if (i_slot_req)
            begin
                tsn_idx <= (tsn_left == 5'h00) ? 5'h00 : tsn_idx + 5'h01;
                if (tsn_left == nhif_pkg::TSN_LOW_LEFT)
                begin
                    slot_low_ev <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_slot_num <= 4'h0;
        end
        else if (i_clk_en && i_slot_req)
        begin
            if (i_slot_bits >= nhif_pkg::SLOT_MAX_BITS)
            begin
                o_slot_num <= tsn_nib;
            end
            else
            begin
                o_slot_num <= tsn_nib >> (3'h4 - i_slot_bits);
            end
        end
    end

    // read mux, data one cycle later
    always_comb
    begin
        next_rdata = 8'h00;
        unique case (i_addr)
            nhif_pkg::STAT_MAIN_ADDR: next_rdata = stat[0];
            nhif_pkg::STAT_TNFC_ADDR: next_rdata = stat[1];
            nhif_pkg::STAT_ERR_ADDR: next_rdata = stat[2];
            nhif_pkg::STAT_PT_ADDR: next_rdata = stat[3];
            nhif_pkg::MASK_MAIN_ADDR: next_rdata = mask[0];
            nhif_pkg::MASK_TNFC_ADDR: next_rdata = mask[1];
            nhif_pkg::MASK_ERR_ADDR: next_rdata = mask[2];
            nhif_pkg::MASK_PT_ADDR: next_rdata = mask[3];
            nhif_pkg::FIFO_DATA_ADDR: next_rdata = i_tx_pop ? 8'h00 : pop_data;
            nhif_pkg::FIFO_STAT1_ADDR: next_rdata = fifo_cnt[7:0];
            nhif_pkg::FIFO_STAT2_ADDR:
            begin
                next_rdata[nhif_pkg::FSTAT2_CNT_HI_LSB +: 2] = fifo_cnt[9:8];
                next_rdata[nhif_pkg::FSTAT2_UNF_BIT] = unf;
                next_rdata[nhif_pkg::FSTAT2_OVF_BIT] = ovf;
            end
            nhif_pkg::TX_LEN1_ADDR: next_rdata = tx_len[7:0];
            nhif_pkg::TX_LEN2_ADDR: next_rdata = {6'h00, tx_len[9:8]};
            default:
            begin
                if (i_addr[7:6] == 2'b01 && i_addr[5:0] <= nhif_pkg::LMEM_LAST)
                begin
                    next_rdata = lmem[i_addr[5:0]];
                end
            end
        endcase
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_rdata <= 8'h00;
        end
        else if (i_clk_en)
        begin
            o_rdata <= i_rd ? next_rdata : 8'h00;
        end
    end
endmodule

//--- testbench/nhif_checker.sv
`timescale 1ns/100ps
module nhif_checker
(
    // clock, reset, enable
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic i_clk_en,
    // register port
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic [7:0] o_rdata,
    // events and framer side
    input wire logic [7:0] i_ev_main,
    input wire logic [7:0] i_ev_tnfc,
    input wire logic [7:0] i_ev_err,
    input wire logic [7:0] i_ev_pt,
    input wire logic i_rx_valid,
    input wire logic i_tx_pop,
    input wire logic [7:0] o_tx_data,
    input wire logic i_slot_req,
    input wire logic [2:0] i_slot_bits,
    input wire logic [3:0] o_slot_num,
    input wire logic [5:0] i_lmem_addr,
    input wire logic [7:0] o_lmem_data,
    input wire logic o_irq
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_rst_n);
    logic any_ev;
    logic stat_rd;
    logic irq_wr;
    assign any_ev = |{i_ev_main, i_ev_tnfc, i_ev_err, i_ev_pt};
    assign stat_rd = i_rd && (i_addr <= nhif_pkg::STAT_PT_ADDR);
    // mask writes move the pin on the edge that takes them, yet two depths are allowed below
    assign irq_wr = i_wr && (i_addr inside {[nhif_pkg::MASK_MAIN_ADDR:nhif_pkg::MASK_PT_ADDR],
        nhif_pkg::CMD_ADDR});
    sequence s_clear_fifo;
        i_wr && i_addr == nhif_pkg::CMD_ADDR && i_wdata[nhif_pkg::CMD_CLEAR_FIFO_BIT] && !i_rx_valid;
    endsequence
    sequence s_quiet_rd;
        stat_rd && !any_ev && !i_slot_req ##1 !any_ev && !i_slot_req;
    endsequence
    a_rdata_idle_zero: assert property (
        i_clk_en && !i_rd |=> o_rdata == 8'h00) else $error("read data not zero when idle");
    a_stat_read_clears: assert property (
        s_quiet_rd ##1 (i_rd && i_addr == $past(i_addr, 2) && !any_ev) |=> o_rdata == 8'h00)
        else $error("status not cleared by read");
    a_cmd_clears_irq: assert property (
        i_wr && i_addr == nhif_pkg::CMD_ADDR && (i_wdata & 8'h07) != 8'h00 && !any_ev
        |=> !o_irq) else $error("irq kept after clearing command");
    a_irq_fall_cause: assert property (
        $fell(o_irq) |-> $past(stat_rd) || $past(irq_wr) || $past(irq_wr, 2))
        else $error("irq fell without read or command");
    a_irq_rise_cause: assert property (
        $rose(o_irq) |-> $past(any_ev) || $past(irq_wr) || $past(irq_wr, 2)
        || $past(i_slot_req, 2) || $past(i_slot_req, 3)) else $error("irq rose without cause");
    a_empty_read_zero: assert property (
        s_clear_fifo ##1 !i_wr ##1 (i_rd && i_addr == nhif_pkg::FIFO_DATA_ADDR && !i_tx_pop)
        |=> o_rdata == 8'h00) else $error("cleared buffer read not zero");
    a_empty_pop_zero: assert property (
        s_clear_fifo ##1 !i_wr ##1 (i_tx_pop && !i_wr && !i_rx_valid) |=> o_tx_data == 8'h00)
        else $error("cleared buffer pop not zero");
    a_slot_msbs_only: assert property (
        i_slot_req && i_slot_bits <= 3'h4 |=> (o_slot_num >> $past(i_slot_bits)) == 4'h0)
        else $error("slot number wider than requested");
    a_lmem_beyond_zero: assert property (
        i_lmem_addr > nhif_pkg::LMEM_LAST |=> o_lmem_data == 8'h00)
        else $error("listen memory beyond end not zero");
endmodule
bind nhif_top nhif_checker u_chk (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_clk_en(i_clk_en),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_ev_main(i_ev_main), .i_ev_tnfc(i_ev_tnfc), .i_ev_err(i_ev_err), .i_ev_pt(i_ev_pt),
    .i_rx_valid(i_rx_valid), .i_tx_pop(i_tx_pop), .o_tx_data(o_tx_data),
    .i_slot_req(i_slot_req), .i_slot_bits(i_slot_bits), .o_slot_num(o_slot_num),
    .i_lmem_addr(i_lmem_addr), .o_lmem_data(o_lmem_data), .o_irq(o_irq));

//--- testbench/nhif_framer.sv
`timescale 1ns/100ps
module nhif_framer
(
    // clock
    input wire logic i_sys_clk,
    // framer outputs toward the block
    output logic o_rx_start,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data,
    output logic o_tx_active,
    output logic o_tx_pop,
    output logic o_slot_req,
    output logic [2:0] o_slot_bits
);
    initial
    begin
        {o_rx_start, o_rx_valid, o_tx_active, o_tx_pop, o_slot_req} = 5'h00;
        o_rx_data = 8'h00;
        o_slot_bits = 3'h0;
    end
    task automatic rx_begin();
        @(posedge i_sys_clk);
        o_rx_start <= 1'b1;
        @(posedge i_sys_clk);
        o_rx_start <= 1'b0;
    endtask
    task automatic rx_byte(input logic [7:0] d);
        @(posedge i_sys_clk);
        o_rx_data <= d;
        o_rx_valid <= 1'b1;
        @(posedge i_sys_clk);
        o_rx_valid <= 1'b0;
        // released data shows a stale inverse, not a copy
        o_rx_data <= ~d;
    endtask
    task automatic set_tx(input logic on);
        @(posedge i_sys_clk);
        o_tx_active <= on;
    endtask
    task automatic tx_pop();
        @(posedge i_sys_clk);
        o_tx_pop <= 1'b1;
        @(posedge i_sys_clk);
        o_tx_pop <= 1'b0;
    endtask
    task automatic slot(input logic [2:0] b);
        @(posedge i_sys_clk);
        o_slot_bits <= b;
        o_slot_req <= 1'b1;
        @(posedge i_sys_clk);
        o_slot_req <= 1'b0;
        o_slot_bits <= ~b;
    endtask
endmodule

//--- testbench/test_nhif_top.sv
`timescale 1ns/100ps
module test_nhif_top;
    logic clk;
    logic rst_n;
    logic clk_en;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
    logic [7:0] ev [4];
    logic [5:0] lmem_addr;
    logic rx_start, rx_valid, tx_active, tx_pop, slot_req;
    logic [7:0] rx_data;
    logic [2:0] slot_bits;
    logic [7:0] o_rdata, o_tx_data, o_lmem_data;
    logic [9:0] o_tx_len;
    logic [3:0] o_slot_num;
    logic o_irq;
    int err_count = 0;
    int n_checks = 0;
    nhif_top dut (.i_sys_clk(clk), .i_rst_n(rst_n), .i_clk_en(clk_en), .i_addr(addr),
        .i_wdata(wdata), .i_wr(wr), .i_rd(rd), .o_rdata(o_rdata), .i_ev_main(ev[0]),
        .i_ev_tnfc(ev[1]), .i_ev_err(ev[2]), .i_ev_pt(ev[3]), .i_rx_start(rx_start),
        .i_rx_valid(rx_valid), .i_rx_data(rx_data), .i_tx_active(tx_active), .i_tx_pop(tx_pop),
        .o_tx_data(o_tx_data), .o_tx_len(o_tx_len), .i_slot_req(slot_req),
        .i_slot_bits(slot_bits), .o_slot_num(o_slot_num), .i_lmem_addr(lmem_addr),
        .o_lmem_data(o_lmem_data), .o_irq(o_irq));
    nhif_framer fr (.i_sys_clk(clk), .o_rx_start(rx_start), .o_rx_valid(rx_valid),
        .o_rx_data(rx_data), .o_tx_active(tx_active), .o_tx_pop(tx_pop), .o_slot_req(slot_req),
        .o_slot_bits(slot_bits));
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %0t: byte got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        n_checks++;
        if (got !== exp)
        begin
            err_count++;
            $display("Error %0t: flag got %b expected %b", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        #1;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk_byte(o_rdata, exp);
    endtask
    task automatic pulse_ev(input int g, input logic [7:0] b);
        @(posedge clk);
        ev[g] <= b;
        @(posedge clk);
        ev[g] <= 8'h00;
        #1;
    endtask
    task automatic lm_chk(input logic [5:0] a, input logic [7:0] exp);
        @(posedge clk);
        lmem_addr <= a;
        @(posedge clk);
        #1 chk_byte(o_lmem_data, exp);
    endtask
    initial
    begin
        repeat (60000) @(posedge clk);
        err_count++;
        $display("Error %0t: run timed out", $time);
        close_out();
    end
    initial
    begin
        logic [3:0] nib;
        {rst_n, wr, rd} = 3'b000;
        clk_en = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        lmem_addr = 6'h00;
        for (int g = 0; g < 4; g++) ev[g] = 8'h00;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        // status 2 goes before the data port, whose empty read sets underflow
        for (int i = 15; i >= 0; i--) rd_chk(8'(i), 8'h00);
        chk_bit(o_irq, 1'b0);
        $display("test reset values done");
        for (int g = 0; g < 4; g++)
        begin
            pulse_ev(g, 8'h01 << g);
            chk_bit(o_irq, 1'b1);
            rd_chk(8'(g), 8'h01 << g);
            chk_bit(o_irq, 1'b0);
            rd_chk(8'(g), 8'h00);
        end
        $display("test status groups done");
        wr_reg(nhif_pkg::MASK_TNFC_ADDR, 8'hff);
        pulse_ev(1, 8'h81);
        chk_bit(o_irq, 1'b0);
        wr_reg(nhif_pkg::MASK_TNFC_ADDR, 8'h7f);
        chk_bit(o_irq, 1'b1);
        rd_chk(nhif_pkg::STAT_TNFC_ADDR, 8'h81);
        wr_reg(nhif_pkg::MASK_TNFC_ADDR, 8'h00);
        pulse_ev(0, 8'h10);
        pulse_ev(2, 8'h04);
        rd_chk(nhif_pkg::STAT_MAIN_ADDR, 8'h10);
        chk_bit(o_irq, 1'b1);
        rd_chk(nhif_pkg::STAT_ERR_ADDR, 8'h04);
        chk_bit(o_irq, 1'b0);
        $display("test masking done");
        for (int b = 0; b < 3; b++)
        begin
            pulse_ev(3, 8'h02);
            pulse_ev(0, 8'h20);
            wr_reg(nhif_pkg::CMD_ADDR, 8'h01 << b);
            chk_bit(o_irq, 1'b0);
            rd_chk(nhif_pkg::STAT_MAIN_ADDR, 8'h00);
            rd_chk(nhif_pkg::STAT_PT_ADDR, 8'h00);
        end
        $display("test clearing commands done");
        wr_reg(nhif_pkg::CMD_ADDR, 8'h04);
        rd_chk(nhif_pkg::FIFO_DATA_ADDR, 8'h00);
        wr_reg(nhif_pkg::FIFO_DATA_ADDR, 8'ha5);
        wr_reg(nhif_pkg::FIFO_DATA_ADDR, 8'h5a);
        rd_chk(nhif_pkg::FIFO_STAT1_ADDR, 8'h02);
        rd_chk(nhif_pkg::FIFO_DATA_ADDR, 8'ha5);
        rd_chk(nhif_pkg::FIFO_DATA_ADDR, 8'h5a);
        rd_chk(nhif_pkg::FIFO_DATA_ADDR, 8'h00);
        rd_chk(nhif_pkg::FIFO_STAT2_ADDR, 8'h10);
        wr_reg(nhif_pkg::CMD_ADDR, 8'h04);
        fr.tx_pop();
        #1 chk_byte(o_tx_data, 8'h00);
        rd_chk(nhif_pkg::FIFO_STAT2_ADDR, 8'h00);
        for (int i = 0; i < 512; i++) wr_reg(nhif_pkg::FIFO_DATA_ADDR, 8'(i + 1));
        rd_chk(nhif_pkg::FIFO_STAT1_ADDR, 8'h00);
        rd_chk(nhif_pkg::FIFO_STAT2_ADDR, 8'h02);
        wr_reg(nhif_pkg::FIFO_DATA_ADDR, 8'hff);
        rd_chk(nhif_pkg::FIFO_STAT2_ADDR, 8'h22);
        fr.tx_pop();
        #1 chk_byte(o_tx_data, 8'h01);
        fr.rx_begin();
        rd_chk(nhif_pkg::FIFO_STAT2_ADDR, 8'h00);
        for (int k = 0; k < 3; k++) fr.rx_byte(8'h30 + 8'(k));
        rd_chk(nhif_pkg::FIFO_STAT1_ADDR, 8'h03);
        for (int k = 0; k < 3; k++) rd_chk(nhif_pkg::FIFO_DATA_ADDR, 8'h30 + 8'(k));
        wr_reg(nhif_pkg::TX_LEN1_ADDR, 8'h02);
        wr_reg(nhif_pkg::TX_LEN2_ADDR, 8'h01);
        chk_byte(o_tx_len[9:2], 8'h40);
        chk_byte(o_tx_len[7:0], 8'h02);
        wr_reg(nhif_pkg::FIFO_DATA_ADDR, 8'h77);
        fr.set_tx(1'b1);
        fr.tx_pop();
        #1 chk_byte(o_tx_data, 8'h77);
        fr.tx_pop();
        fr.set_tx(1'b0);
        rd_chk(nhif_pkg::FIFO_STAT2_ADDR, 8'h10);
        $display("test buffer done");
        wr_reg(nhif_pkg::LMEM_BASE_ADDR, 8'hc3);
        wr_reg(nhif_pkg::LMEM_BASE_ADDR + 8'h0b, 8'h3c);
        lm_chk(6'h00, 8'hc3);
        lm_chk(6'h0b, 8'h3c);
        lm_chk(6'h32, 8'h00);
        // slot number i holds the value i mod 16, so the expected msbs follow the index
        for (int k = 0; k < 12; k++)
            wr_reg(nhif_pkg::LMEM_BASE_ADDR + 8'h24 + 8'(k), {4'(2 * k), 4'(2 * k + 1)});
        rd_chk(nhif_pkg::STAT_PT_ADDR, 8'h00);
        for (int i = 0; i < 20; i++)
        begin
            nib = 4'(i);
            fr.slot(3'(i % 5));
            #1 chk_byte({4'h0, o_slot_num}, {4'h0, nib >> (4 - (i % 5))});
            if (i == 18)
                rd_chk(nhif_pkg::STAT_PT_ADDR, 8'h00);
        end
        repeat (3) @(posedge clk);
        #1 chk_bit(o_irq, 1'b1);
        rd_chk(nhif_pkg::STAT_PT_ADDR, 8'h80);
        chk_bit(o_irq, 1'b0);
        $display("test slot numbers done");
        close_out();
    end
endmodule
